// *** hw/dcf_pkg.sv ***
// Shared constants and flag carriers for the dual-clock FIFO controller
package dcf_pkg;

    // Storage of one memory block, without and with the ninth bit per byte
    localparam int BLOCK_BITS_PLAIN  = 4096;
    localparam int BLOCK_BITS_PARITY = 4608;
    localparam int PARITY_GRAIN      = 9;

    // Port shapes a block supports, narrowest and widest
    localparam int MIN_WIDTH = 1;
    localparam int MAX_WIDTH = 36;

    // Flag values while reset is held
    localparam logic RST_FULL   = 1'b0;
    localparam logic RST_ALMOST_FULL_FLAG  = 1'b0;
    localparam logic RST_EMPTY  = 1'b1;
    localparam logic RST_ALMOST_EMPTY_FLAG = 1'b1;

    typedef struct packed {
        logic full;
        logic almost_full_flag;
    } dcf_wr_flags_t;

    typedef struct packed {
        logic empty;
        logic almost_empty_flag;
    } dcf_rd_flags_t;

    function automatic bit dcf_width_ok(input int w);
        return (w == 1) || (w == 2) || (w == 4) || (w == 9) || (w == 18) ||
               (w == 36);
    endfunction

    // Words per block at a given port width
    function automatic int dcf_depth_of(input int w);
        return (w % PARITY_GRAIN == 0) ? BLOCK_BITS_PARITY / w
                                       : BLOCK_BITS_PLAIN / w;
    endfunction

endpackage

// *** hw/dcf_fifo.sv ***
// Dual-clock FIFO controller with gray pointers and programmable flags

// Operation
// [R1] Each write edge with enable high stores the write data word.
// [R2] Each read edge with enable high removes and presents next word.
// [R3] Full flag lives in write domain and blocks writes while set.
// [R4] Empty flag lives in read domain and blocks reads while set.
// [R5] Both pointers are gray-coded when crossing between clock domains.
// [R6] Almost-full and almost-empty flags follow user-programmable thresholds.
// [R7] Write and read widths chosen independently from 1 up to 36 bits; code takes 1, 2, 4, 9, 18 or 36, wider a power-of-two multiple of narrower.
// [R8] Read and write ports run concurrently on unrelated clocks.
// [R9] Reset empties the FIFO: pointers cleared, empty set, full cleared.
// [R10] Depth follows data width and number of blocks combined.
// [R11] Every port action happens only on its own clock edge.
// [R12] Read output either direct or delayed by one extra register.
// [R13] Thresholds are static word counts, flags evaluated per port domain.
module dcf_fifo #(
    parameter int WR_W   = 36,
    parameter int RD_W   = 36,
    parameter int BLOCKS = 1,
    // Threshold width: fill count in wide words, one bit above the address
    localparam int TH_W  = $clog2(BLOCKS *
        dcf_pkg::dcf_depth_of((WR_W > RD_W) ? WR_W : RD_W)) + 1
) (
    input  wire logic                    sys_clk_i,
    input  wire logic                    rd_clk_i,
    input  wire logic                    reset_n_i,
    input  wire logic                    wr_en_i,
    input  wire logic [WR_W-1:0]         write_data_in_i,
    input  wire logic [TH_W-1:0]         af_thresh_i,
    output dcf_pkg::dcf_wr_flags_t       wr_flags_o,
    input  wire logic                    rd_en_i,
    input  wire logic [TH_W-1:0]         ae_thresh_i,
    input  wire logic                    pipe_mode_i,
    output logic      [RD_W-1:0]         rd_data_o,
    output logic                         rd_valid_o,
    output dcf_pkg::dcf_rd_flags_t       rd_flags_o
);
    import dcf_pkg::*;

    localparam int WIDE     = (WR_W > RD_W) ? WR_W : RD_W;
    localparam int NARR     = (WR_W > RD_W) ? RD_W : WR_W;
    localparam int DEPTH    = BLOCKS * dcf_depth_of(WIDE);  // [R10]
    localparam int AW       = $clog2(DEPTH);
    localparam int PW       = AW + 1;
    localparam int WR_RATIO = WIDE / WR_W;
    localparam int RD_RATIO = WIDE / RD_W;
    localparam int WSUB_W   = (WR_RATIO > 1) ? $clog2(WR_RATIO) : 1;
    localparam int RSUB_W   = (RD_RATIO > 1) ? $clog2(RD_RATIO) : 1;
    localparam logic [WSUB_W-1:0] WSUB_LAST = WSUB_W'(WR_RATIO - 1);
    localparam logic [RSUB_W-1:0] RSUB_LAST = RSUB_W'(RD_RATIO - 1);
    localparam logic [PW-1:0]     DEPTH_CNT = PW'(DEPTH);

    // Port shapes must be block shapes and nest by a power of two
    if (!dcf_width_ok(WR_W) || !dcf_width_ok(RD_W) ||
        (WIDE % NARR != 0) || ((WIDE / NARR) & (WIDE / NARR - 1)) != 0 ||
        BLOCKS < 1 || (BLOCKS & (BLOCKS - 1)) != 0) begin : g_bad_cfg
        $error("dcf_fifo: unsupported width or block count"); // [R7]
    end

    function automatic logic [PW-1:0] bin2gray(input logic [PW-1:0] b);
        return b ^ (b >> 1);
    endfunction

    function automatic logic [PW-1:0] gray2bin(input logic [PW-1:0] g);
        logic [PW-1:0] b;
        b[PW-1] = g[PW-1];
        for (int i = PW - 2; i >= 0; i--) begin
            b[i] = b[i+1] ^ g[i];
        end
        return b;
    endfunction

    logic [WIDE-1:0] mem [DEPTH];

    // ---------------- Write domain ----------------
    logic [PW-1:0]     wbin_r, wgray_r, rgray_s1_r, rgray_s2_r;
    logic [PW-1:0]     rd_gray_r;
    logic [PW-1:0]     af_s1_r, af_s2_r;
    logic [WSUB_W-1:0] wsub_r;
    logic [WIDE-1:0]   wbuf_r;
    logic [WIDE-1:0]   wword;

    wire              w_take    = wr_en_i && !wr_flags_o.full;     // [R3]
    wire              w_last    = (wsub_r == WSUB_LAST);
    wire              w_commit  = w_take && w_last;                // [R1]
    wire [PW-1:0]     wbin_nxt  = wbin_r + PW'(w_commit);
    wire [PW-1:0]     rbin_w    = gray2bin(rgray_s2_r);
    wire [PW-1:0]     wcnt_nxt  = wbin_nxt - rbin_w;
    wire [PW-1:0]     wcnt_now  = wbin_r - rbin_w;
    wire [WSUB_W-1:0] wsub_nxt  = !w_take ? wsub_r :
                                  (w_last ? '0 : wsub_r + 1'b1);

    // Narrow writes fill the wide word from the low end upward
    always_comb begin
        wword = wbuf_r;
        wword[wsub_r*WR_W +: WR_W] = write_data_in_i;
    end

    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            wbin_r     <= '0;                                      // [R9]
            wgray_r    <= '0;
            rgray_s1_r <= '0;
            rgray_s2_r <= '0;
            af_s1_r    <= '0;
            af_s2_r    <= '0;
            wsub_r     <= '0;
            wbuf_r     <= '0;
            wr_flags_o <= '{full: RST_FULL, almost_full_flag: RST_ALMOST_FULL_FLAG};
        end else begin
            wbin_r     <= wbin_nxt;                                // [R11]
            wgray_r    <= bin2gray(wbin_nxt);                      // [R5]
            rgray_s1_r <= rd_gray_r;                               // [R8]
            rgray_s2_r <= rgray_s1_r;
            af_s1_r    <= af_thresh_i;                             // [R13]
            af_s2_r    <= af_s1_r;
            wsub_r     <= wsub_nxt;
            if (w_take) begin
                wbuf_r <= wword;
            end
            wr_flags_o.full             <= (wcnt_nxt == DEPTH_CNT); // [R3]
            wr_flags_o.almost_full_flag <= (wcnt_nxt >= af_s2_r);   // [R6]
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (w_commit) begin
            mem[wbin_r[AW-1:0]] <= wword;                          // [R1]
        end
    end

    // ---------------- Read domain ----------------
    logic [PW-1:0]     rbin_r, wgray_s1_r, wgray_s2_r;
    logic [PW-1:0]     ae_s1_r, ae_s2_r;
    logic              pipe_s1_r, pipe_s2_r;
    logic [RSUB_W-1:0] rsub_r;
    logic [RD_W-1:0]   stage_r;
    logic              stage_vld_r;
    logic [WIDE-1:0]   rd_word;

    wire              r_take   = rd_en_i && !rd_flags_o.empty;     // [R4]
    wire              r_last   = (rsub_r == RSUB_LAST);
    wire              r_adv    = r_take && r_last;                 // [R2]
    wire [PW-1:0]     rbin_nxt = rbin_r + PW'(r_adv);
    wire [PW-1:0]     wbin_r_s = gray2bin(wgray_s2_r);
    wire [PW-1:0]     rcnt_nxt = wbin_r_s - rbin_nxt;
    wire [PW-1:0]     rcnt_now = wbin_r_s - rbin_r;
    wire [RSUB_W-1:0] rsub_nxt = !r_take ? rsub_r :
                                 (r_last ? '0 : rsub_r + 1'b1);
    wire [RD_W-1:0]   rd_slice = rd_word[rsub_r*RD_W +: RD_W];

    assign rd_word = mem[rbin_r[AW-1:0]];

    always_ff @(posedge rd_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            rbin_r      <= '0;                                     // [R9]
            rd_gray_r   <= '0;
            wgray_s1_r  <= '0;
            wgray_s2_r  <= '0;
            ae_s1_r     <= '0;
            ae_s2_r     <= '0;
            pipe_s1_r   <= 1'b0;
            pipe_s2_r   <= 1'b0;
            rsub_r      <= '0;
            stage_r     <= '0;
            stage_vld_r <= 1'b0;
            rd_data_o   <= '0;
            rd_valid_o  <= 1'b0;
            rd_flags_o  <= '{empty: RST_EMPTY, almost_empty_flag: RST_ALMOST_EMPTY_FLAG};
        end else begin
            rbin_r      <= rbin_nxt;                               // [R11]
            rd_gray_r   <= bin2gray(rbin_nxt);                     // [R5]
            wgray_s1_r  <= wgray_r;                                // [R8]
            wgray_s2_r  <= wgray_s1_r;
            ae_s1_r     <= ae_thresh_i;                            // [R13]
            ae_s2_r     <= ae_s1_r;
            pipe_s1_r   <= pipe_mode_i;
            pipe_s2_r   <= pipe_s1_r;
            rsub_r      <= rsub_nxt;
            stage_vld_r <= r_take;
            if (r_take) begin
                stage_r <= rd_slice;
            end
            // Direct mode loads the word now, pipelined mode one edge later
            rd_valid_o <= pipe_s2_r ? stage_vld_r : r_take;        // [R12]
            if (pipe_s2_r && stage_vld_r) begin
                rd_data_o <= stage_r;
            end else if (!pipe_s2_r && r_take) begin
                rd_data_o <= rd_slice;                             // [R2]
            end
            rd_flags_o.empty             <= (rcnt_nxt == '0);      // [R4]
            rd_flags_o.almost_empty_flag <= (rcnt_nxt <= ae_s2_r); // [R6]
        end
    end

    // ---------------- Checks ----------------
    a_full_blocks_write: assert property ( // [R3]
        @(posedge sys_clk_i) disable iff (!reset_n_i)
        wr_flags_o.full |=> $stable(wbin_r) || (wbin_r == $past(wbin_r)))
        else $error("write pointer moved while full");

    a_no_overflow: assert property ( // [R3]
        @(posedge sys_clk_i) disable iff (!reset_n_i)
        wcnt_now <= DEPTH_CNT)
        else $error("write side fill level above depth");

    a_write_advance: assert property ( // [R1]
        @(posedge sys_clk_i) disable iff (!reset_n_i)
        wr_en_i && !wr_flags_o.full && w_last |=>
            wbin_r == $past(wbin_r) + 1'b1)
        else $error("accepted write did not advance pointer");

    a_wgray_one_bit: assert property ( // [R5]
        @(posedge sys_clk_i) disable iff (!reset_n_i)
        $countones(wgray_r ^ $past(wgray_r)) <= 1)
        else $error("write gray pointer changed more than one bit");

    a_almost_full_flag_level: assert property ( // [R6]
        @(posedge sys_clk_i) disable iff (!reset_n_i)
        $past(reset_n_i) && $stable(rgray_s2_r) && $stable(af_s2_r) |->
            wr_flags_o.almost_full_flag == (wcnt_now >= af_s2_r))
        else $error("almost full disagrees with fill level");

    a_empty_blocks_read: assert property ( // [R4]
        @(posedge rd_clk_i) disable iff (!reset_n_i)
        rd_flags_o.empty && rd_en_i |=> rbin_r == $past(rbin_r) &&
            (!rd_valid_o || $past(pipe_s2_r)))
        else $error("read taken while empty");

    a_no_underflow: assert property ( // [R4]
        @(posedge rd_clk_i) disable iff (!reset_n_i)
        rcnt_now <= DEPTH_CNT)
        else $error("read pointer passed write pointer");

    a_direct_valid: assert property ( // [R12]
        @(posedge rd_clk_i) disable iff (!reset_n_i)
        r_take && !pipe_s2_r |=> rd_valid_o && rd_data_o == $past(rd_slice))
        else $error("direct read data not presented next edge");

    a_piped_valid: assert property ( // [R12]
        @(posedge rd_clk_i) disable iff (!reset_n_i)
        r_take && pipe_s2_r && $stable(pipe_s2_r) ##1 $stable(pipe_s2_r)
            |=> rd_valid_o && rd_data_o == $past(rd_slice, 2))
        else $error("pipelined read data not two edges later");

endmodule // dcf_fifo

// *** bench/dcf_reader.sv ***
// Consumer model for the read port of the FIFO
module dcf_reader (
    input  wire logic rd_clk_i,
    input  wire logic reset_n_i,
    input  wire logic go_i,
    output logic      rd_en_o
);
    timeunit 1ns;
    timeprecision 100ps;
    // Asks on every edge while told to, empty or not; stalls when go is low
    always @(posedge rd_clk_i or negedge reset_n_i) begin
        if (!reset_n_i)
            rd_en_o <= 1'b0;
        else
            rd_en_o <= #2 go_i;
    end
endmodule // dcf_reader

// *** bench/test_dcf_fifo.sv ***
// Self-checking bench for the dual-clock FIFO controller
module test_dcf_fifo;
    timeunit 1ns;
    timeprecision 100ps;
    import dcf_pkg::*;
    logic          sys_clk = 0, rd_clk = 0, reset_n = 0;
    logic          wr_en = 0, pipe = 0, go = 0, d1 = 0, d2 = 0;
    logic [35:0]   wdata = '0, rd_data;
    logic [7:0]    af_th = 8'h64, ae_th = 8'h04;
    logic          rd_valid, rd_en;
    dcf_wr_flags_t wf;
    dcf_rd_flags_t rf;
    logic [35:0]   exp_q[$];
    int            num_errors = 0, tests_run = 0;

    always #20 sys_clk = ~sys_clk;
    always #17 rd_clk = ~rd_clk;

    dcf_fifo #(.WR_W(36), .RD_W(36), .BLOCKS(1)) dcf_fifo_i (
        .sys_clk_i(sys_clk), .rd_clk_i(rd_clk), .reset_n_i(reset_n),
        .wr_en_i(wr_en), .write_data_in_i(wdata), .af_thresh_i(af_th),
        .wr_flags_o(wf), .rd_en_i(rd_en), .ae_thresh_i(ae_th),
        .pipe_mode_i(pipe), .rd_data_o(rd_data), .rd_valid_o(rd_valid),
        .rd_flags_o(rf));
    dcf_reader dcf_reader_i (.rd_clk_i(rd_clk), .reset_n_i(reset_n),
        .go_i(go), .rd_en_o(rd_en));

    task automatic check(input logic c, input string m);
        tests_run++;
        if (c !== 1'b1) begin
            num_errors++;
            $display("FAIL at %0t: %s", $time, m);
        end
    endtask

    task automatic final_report();
        $display("Counts: %0d compares, %0d mismatches", tests_run,
                 num_errors);
        if (num_errors == 0 && tests_run > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    // Back-to-back writes; a word is expected only if full was low
    task automatic wr_burst(input int cnt, input int base);
        for (int i = 0; i <= cnt; i++) begin
            @(posedge sys_clk);
            if (wr_en && wf.full === 1'b0)
                exp_q.push_back(wdata);
            #2 wr_en = (i < cnt);
            wdata = 36'(base + i);
        end
    endtask

    task automatic drain();
        go = 1;
        for (int i = 0; i < 600; i++) begin
            if (exp_q.size() == 0 && rf.empty === 1'b1)
                break;
            @(posedge rd_clk);
        end
        check(exp_q.size() == 0, "stored words not read back");
    endtask

    // Read side monitor: data order and output latency per mode
    always @(posedge rd_clk) begin
        if (rd_valid === 1'b1 && exp_q.size() == 0)
            check(1'b0, "word read that was never stored");
        else if (rd_valid === 1'b1)
            check(rd_data === exp_q.pop_front(), "read data");
        if (reset_n)
            check(rd_valid === (pipe ? d2 : d1), "valid latency");
        d2 <= d1 & reset_n;
        d1 <= rd_en & ~rf.empty & reset_n;
    end

    initial begin
        #1000000;
        num_errors++;
        $display("FAIL at %0t: watchdog expired", $time);
        final_report();
    end

    initial begin
        repeat (12) @(posedge sys_clk);
        #2 reset_n = 1;
        repeat (3) @(posedge sys_clk);
        #2 check({wf, rf, rd_valid} === 5'b00110, "reset flags");
        $display("test reset done");
        drain();
        wr_burst(20, 'h100);
        drain();
        $display("test stream done");
        #2 go = 0;
        wr_burst(99, 'h200);
        check(wf.almost_full_flag === 1'b0, "almost full early");
        wr_burst(1, 'h300);
        check(wf.almost_full_flag === 1'b1, "almost full late");
        wr_burst(28, 'h400);
        check(wf.full === 1'b1, "not full at depth");
        wr_burst(3, 'h900);
        check(exp_q.size() == 128, "write taken while full");
        repeat (12) @(posedge rd_clk);
        check(rf === 2'b00, "read flags with data");
        drain();
        check(rf === 2'b11, "read flags after drain");
        repeat (6) @(posedge sys_clk);
        check(wf === 2'b00, "write flags after drain");
        $display("test fill done");
        #2 go = 0;
        pipe = 1;
        repeat (6) @(posedge rd_clk);
        wr_burst(16, 'h500);
        drain();
        $display("test pipelined done");
        #2 go = 0;
        wr_burst(10, 'h600);
        @(posedge sys_clk);
        #2 reset_n = 0;
        exp_q.delete();
        repeat (3) @(posedge sys_clk);
        check({wf, rf, rd_valid} === 5'b00110, "flags in reset");
        #2 reset_n = 1;
        repeat (4) @(posedge sys_clk);
        go = 1;
        repeat (20) @(posedge rd_clk);
        check(rf.empty === 1'b1, "not empty after reset");
        $display("test reset mid-run done");
        final_report();
    end
endmodule // test_dcf_fifo
